/* File: rtl/bac_top.sv */
// Purpose: per-port burst address counter with mask and mirror registers
// Assumes: port pins are driven on the rising edge of hclk
// Notes:   AHB-Lite slave gives status and an alternative command source
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - increment changes only unmasked counter bits
// - step one, or two when mask bit0 clear
// - all unmasked ones: next increment reloads mirror
// - wrap flag low when increment hits top
// - wrap flag high on other increment results
// - clear, load, mask reset, mask load, reset raise flag
// - flag may drive clear directly at speed
// - hold keeps all three registers unchanged
// - counter readback on address lines, next edge
// - mask readback on address lines, next edge
// - repeated increments cycle start to top
// - mask reset sets every mask bit
// - master reset sets every mask bit
// - mask load captures the address lines
// - mask wide enough for full memory
// - masked counter bits keep loaded value
// - select high decodes the counter operations
// - select low decodes the mask operations
// - clear zeroes unmasked counter and mirror bits
// - load writes counter and mirror together
module bac_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        master_reset_n,
  input  wire logic        counter_mask_select,
  input  wire logic        counter_clear_n,
  input  wire logic        addr_strobe_n,
  input  wire logic        count_enable_n,
  input  wire logic        chip_en_low_active,
  input  wire logic        chip_en_high_active,
  input  wire logic [17:0] addr_in,
  output logic      [17:0] addr_out,
  output logic             addr_oe,
  output logic             dq_off,
  output logic      [17:0] count_addr,
  output logic             wrap_flag_n
);

  logic                 rst_n;
  logic                 arst_n;

  assign arst_n = hresetn & master_reset_n;

  bac_rst_sync bac_rst_sync_inst (
    .hclk   (hclk),
    .arst_n (arst_n),
    .rst_n  (rst_n)
  );
  ////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic                 wr_pend_q, wr_pend_d;
  logic [7:0]           wr_off_q, wr_off_d;
  logic [31:0]          rdata_q, rdata_d;
  logic                 own_q, own_d;
  logic                 sw_vld_q, sw_vld_d;
  bac_pkg::bac_port_type sw_cmd_q, sw_cmd_d;
  logic                 ready_q;
  logic                 resp_q;
  ////////////////////////////////////////////////////////////////////////////
  // counter state
  logic [17:0]          cnt_q, cnt_d;
  logic [17:0]          mask_q, mask_d;
  logic [17:0]          mir_q, mir_d;
  logic                 flag_q, flag_d;
  logic [17:0]          rb_q, rb_d;
  logic                 rb_oe_q, rb_oe_d;
  logic                 dq_off_q, dq_off_d;

  bac_pkg::bac_port_type pins;
  bac_pkg::bac_port_type port_eff;
  bac_pkg::bac_op_type   op;
  logic [17:0]          inc_nxt;
  logic                 at_top;
  logic                 ce_active;
  logic                 take;
  logic [7:0]           off_a;

  assign pins.select   = counter_mask_select;
  assign pins.clear_n  = counter_clear_n;
  assign pins.strobe_n = addr_strobe_n;
  assign pins.en_n     = count_enable_n;
  assign pins.addr     = addr_in;
  assign ce_active     = !chip_en_low_active && chip_en_high_active;

  // software owns the port only while the control bit is set
  assign port_eff = own_q ? (sw_vld_q ? sw_cmd_q : bac_pkg::PORT_IDLE)
                          : pins;
  // op decode, reserved acts as hold
  assign op       = bac_pkg::bac_decode(port_eff);

  bac_incr bac_incr_inst (
    .cnt    (cnt_q),
    .mask   (mask_q),
    .mirror (mir_q),
    .nxt    (inc_nxt),
    .at_top (at_top)
  );
  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  assign take  = hsel && htrans[1] && hready;
  assign off_a = (haddr[31:8] == 24'h000000) ? haddr[7:0]
                                             : bac_pkg::OFF_NONE;

  always_comb
  begin
    wr_pend_d = take && hwrite;
    wr_off_d  = off_a;
    rdata_d   = 32'h00000000;
    own_d     = own_q;
    sw_vld_d  = 1'b0;
    sw_cmd_d  = sw_cmd_q;
    if (take && !hwrite) begin
      if (off_a == bac_pkg::OFF_CTRL)
        rdata_d[bac_pkg::CTRL_OWN_BIT] = own_q;
      else if (off_a == bac_pkg::OFF_COUNT)
        rdata_d[17:0] = cnt_q;
      else if (off_a == bac_pkg::OFF_MASK)
        rdata_d[17:0] = mask_q;
      else if (off_a == bac_pkg::OFF_MIRROR)
        rdata_d[17:0] = mir_q;
      else if (off_a == bac_pkg::OFF_STATUS)
        rdata_d[bac_pkg::STAT_WRAP_BIT] = flag_q;
    end
    if (wr_pend_q) begin
      if (wr_off_q == bac_pkg::OFF_CTRL) begin
        own_d = hwdata[bac_pkg::CTRL_OWN_BIT];
      end else if (wr_off_q == bac_pkg::OFF_CMD) begin
        sw_vld_d         = 1'b1;
        sw_cmd_d.addr    = hwdata[17:0];
        sw_cmd_d.en_n    = hwdata[bac_pkg::CMD_EN_N_BIT];
        sw_cmd_d.strobe_n = hwdata[bac_pkg::CMD_STB_N_BIT];
        sw_cmd_d.clear_n = hwdata[bac_pkg::CMD_CLR_N_BIT];
        sw_cmd_d.select  = hwdata[bac_pkg::CMD_SEL_BIT];
      end
    end
  end

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= bac_pkg::OFF_NONE;
      rdata_q   <= 32'h00000000;
      own_q     <= bac_pkg::CTRL_OWN_RST;
      sw_vld_q  <= 1'b0;
      sw_cmd_q  <= bac_pkg::PORT_IDLE;
      ready_q   <= 1'b1;
      resp_q    <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_off_q  <= wr_off_d;
      rdata_q   <= rdata_d;
      own_q     <= own_d;
      sw_vld_q  <= sw_vld_d;
      sw_cmd_q  <= sw_cmd_d;
      ready_q   <= 1'b1;
      resp_q    <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // counter, mask and mirror
  always_comb
  begin
    cnt_d    = cnt_q;
    mask_d   = mask_q;
    mir_d    = mir_q;
    flag_d   = flag_q;
    rb_d     = rb_q;
    rb_oe_d  = 1'b0;
    dq_off_d = 1'b0;
    case (op)
      bac_pkg::OP_INC:
      begin
        cnt_d  = inc_nxt;
        flag_d = ((inc_nxt & mask_q) != mask_q);
      end
      bac_pkg::OP_CLR:
      begin
        // zero unmasked bits, tied flag safe
        cnt_d  = cnt_q & ~mask_q;
        mir_d  = mir_q & ~mask_q;
        flag_d = 1'b1;
      end
      bac_pkg::OP_LOAD:
      begin
        cnt_d  = port_eff.addr;
        mir_d  = port_eff.addr;
        flag_d = 1'b1;
      end
      bac_pkg::OP_MASTER_RESET_N:
      begin
        // all mask bits set, flag raised
        mask_d = bac_pkg::MASK_RST;
        flag_d = 1'b1;
      end
      bac_pkg::OP_MLOAD:
      begin
        mask_d = port_eff.addr;
        flag_d = 1'b1;
      end
      bac_pkg::OP_CRB:
      begin
        rb_d     = cnt_q;
        rb_oe_d  = 1'b1;
        dq_off_d = ce_active;
      end
      bac_pkg::OP_MRB:
      begin
        rb_d     = mask_q;
        rb_oe_d  = 1'b1;
        dq_off_d = ce_active;
      end
      default:
      begin
        cnt_d = cnt_q;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n) begin
      cnt_q    <= bac_pkg::CNT_RST;
      mask_q   <= bac_pkg::MASK_RST;
      mir_q    <= bac_pkg::CNT_RST;
      flag_q   <= 1'b1;
      rb_q     <= bac_pkg::CNT_RST;
      rb_oe_q  <= 1'b0;
      dq_off_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      mask_q   <= mask_d;
      mir_q    <= mir_d;
      flag_q   <= flag_d;
      rb_q     <= rb_d;
      rb_oe_q  <= rb_oe_d;
      dq_off_q <= dq_off_d;
    end
  end

  assign hreadyout   = ready_q;
  assign hresp       = resp_q;
  assign hrdata      = rdata_q;
  assign addr_out    = rb_q;
  assign addr_oe     = rb_oe_q;
  assign dq_off      = dq_off_q;
  assign count_addr  = cnt_q;
  assign wrap_flag_n = flag_q;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!rst_n);

  a_masked_bits_frozen: assert property (
    (op == bac_pkg::OP_INC && !at_top) |=>
      (((cnt_q ^ $past(cnt_q)) & ~$past(mask_q)) == 18'h00000))
    else $error("masked counter bit changed on increment");
  a_step_by_two: assert property (
    (op == bac_pkg::OP_INC && !at_top && !mask_q[0]) |=>
      (cnt_q[0] == $past(cnt_q[0])) && (cnt_q[1] != $past(cnt_q[1])))
    else $error("increment by two wrong");
  a_wrap_to_mirror: assert property (
    (op == bac_pkg::OP_INC && at_top) |=> (cnt_q == $past(mir_q)))
    else $error("wrap did not reload mirror");
  a_flag_on_incr: assert property (
    (op == bac_pkg::OP_INC) |=>
      (wrap_flag_n == ((cnt_q & mask_q) != mask_q)))
    else $error("wrap flag wrong after increment");
  // flag raised by clear, load, mask reset and mask load
  a_flag_raised: assert property (
    (op inside {bac_pkg::OP_CLR, bac_pkg::OP_LOAD,
                bac_pkg::OP_MASTER_RESET_N, bac_pkg::OP_MLOAD}) |=> wrap_flag_n)
    else $error("wrap flag not raised");
  a_hold_stable: assert property (
    (op == bac_pkg::OP_HOLD) |=>
      $stable(cnt_q) && $stable(mask_q) && $stable(mir_q))
    else $error("hold changed a register");
  a_cnt_readback: assert property (
    (op == bac_pkg::OP_CRB) |=>
      addr_oe && (addr_out == $past(cnt_q)) && (dq_off == $past(ce_active)))
    else $error("counter readback wrong");
  a_mask_reset: assert property (
    (op == bac_pkg::OP_MASTER_RESET_N) |=> (mask_q == 18'h3FFFF))
    else $error("mask reset wrong");
  a_mask_load: assert property (
    (op == bac_pkg::OP_MLOAD) |=> (mask_q == $past(port_eff.addr)))
    else $error("mask load wrong");
  a_clear_unmasked: assert property (
    (op == bac_pkg::OP_CLR) |=> ((cnt_q & mask_q) == 18'h00000)
      && (mir_q == ($past(mir_q) & ~mask_q)))
    else $error("counter clear wrong");
  a_load_both: assert property (
    (op == bac_pkg::OP_LOAD) |=>
      (cnt_q == $past(port_eff.addr)) && (mir_q == cnt_q))
    else $error("counter load wrong");

endmodule : bac_top

/* File: rtl/bac_pkg.sv */
// Purpose: shared constants, types and op decode for the burst counter
// Assumes: port strobes are synchronous to hclk
// Notes:   register offsets are byte addresses on a 32-bit AHB-Lite bus
package bac_pkg;

  localparam int          ADDR_W     = 18;
  localparam logic [17:0] MASK_RST   = 18'h3FFFF;
  localparam logic [17:0] CNT_RST    = 18'h00000;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_CMD    = 8'h04;
  localparam logic [7:0]  OFF_COUNT  = 8'h08;
  localparam logic [7:0]  OFF_MASK   = 8'h0C;
  localparam logic [7:0]  OFF_MIRROR = 8'h10;
  localparam logic [7:0]  OFF_STATUS = 8'h14;
  localparam logic [7:0]  OFF_NONE   = 8'hFF;

  localparam int          CTRL_OWN_BIT   = 0;
  localparam int          STAT_WRAP_BIT  = 0;
  localparam int          CMD_EN_N_BIT   = 18;
  localparam int          CMD_STB_N_BIT  = 19;
  localparam int          CMD_CLR_N_BIT  = 20;
  localparam int          CMD_SEL_BIT    = 21;
  localparam logic        CTRL_OWN_RST   = 1'b0;

  typedef struct packed {
    logic        select;
    logic        clear_n;
    logic        strobe_n;
    logic        en_n;
    logic [17:0] addr;
  } bac_port_type;

  localparam bac_port_type PORT_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 18'h00000};

  typedef enum logic [3:0] {
    OP_HOLD  = 4'h0,
    OP_INC   = 4'h1,
    OP_LOAD  = 4'h3,
    OP_CLR   = 4'h2,
    OP_CRB   = 4'h6,
    OP_MASTER_RESET_N  = 4'h7,
    OP_MLOAD = 4'h5,
    OP_MRB   = 4'h4,
    OP_RSVD  = 4'hC
  } bac_op_type;

  function automatic bac_op_type bac_decode(input bac_port_type p);
    bac_op_type op;
    op = OP_HOLD;
    if (p.select) begin
      if (!p.clear_n)
        op = OP_CLR;
      else if (!p.strobe_n && !p.en_n)
        op = OP_LOAD;
      else if (!p.strobe_n)
        op = OP_CRB;
      else if (!p.en_n)
        op = OP_INC;
      else
        op = OP_HOLD;
    end else begin
      if (!p.clear_n)
        op = OP_MASTER_RESET_N;
      else if (!p.strobe_n && !p.en_n)
        op = OP_MLOAD;
      else if (!p.strobe_n)
        op = OP_MRB;
      else
        op = OP_RSVD;
    end
    return op;
  endfunction : bac_decode

endpackage : bac_pkg

/* File: rtl/bac_rst_sync.sv */
// Purpose: reset bridge, asserts at once and releases on the clock
// Assumes: arst_n may fall at any time
// Notes:   second stage is the only reader of the first
module bac_rst_sync (
  input  wire logic hclk,
  input  wire logic arst_n,
  output logic      rst_n
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge hclk or negedge arst_n)
  begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign rst_n = sync_q;

endmodule : bac_rst_sync

/* File: rtl/bac_incr.sv */
// Purpose: masked increment with wrap to the mirror value
// Assumes: mask is zeros, then ones, optionally one trailing zero
// Notes:   purely combinational
module bac_incr (
  input  wire logic [17:0] cnt,
  input  wire logic [17:0] mask,
  input  wire logic [17:0] mirror,
  output logic      [17:0] nxt,
  output logic             at_top
);

  logic [17:0] filled;
  logic [17:0] sum;

  // masked bits forced to one so the carry passes a masked bit 0 (+2)
  assign filled = cnt | ~mask;
  assign sum    = filled + 18'h00001;
  assign at_top = ((cnt & mask) == mask);
  assign nxt    = at_top ? mirror : ((cnt & ~mask) | (sum & mask));

endmodule : bac_incr

/* File: verif/bac_host.sv */
// Purpose: port controller model that drives the counter strobes
// Assumes: strobes change by non-blocking assignment at rising hclk
// Notes:   address lines resolve between host and device drive
module bac_host (
  input  wire logic             hclk,
  input  wire logic             tie_wrap,
  input  wire logic             wrap_flag_n,
  input  wire logic      [17:0] addr_out,
  input  wire logic             addr_oe,
  output bac_pkg::bac_port_type port,
  output logic           [17:0] addr_wire,
  output logic                  ce_n,
  output logic                  ce
);
  timeunit 1ns;
  timeprecision 1ps;

  bac_pkg::bac_port_type port_q = bac_pkg::PORT_IDLE;

  initial
  begin
    ce_n = 1'b1;
    ce   = 1'b0;
  end

  task automatic apply(input bac_pkg::bac_port_type p, input logic en);
    port_q <= p;
    ce_n   <= ~en;
    ce     <= en;
  endtask : apply

  always_comb
  begin
    port = port_q;
    if (tie_wrap)
      port.clear_n = wrap_flag_n;
  end

  // device drive wins while reading back
  assign addr_wire = addr_oe ? addr_out : port_q.addr;
endmodule : bac_host

/* File: verif/bac_tb_top.sv */
// Purpose: self-checking bench for the burst address counter
// Assumes: one slave, hready tied to hreadyout
// Notes:   expected state kept by a small reference model
module bac_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  hclk = 1'b0;
  logic                  hresetn, hsel, hwrite, master_reset_n, tie;
  logic           [31:0] haddr, hwdata, hrdata, rd;
  logic            [1:0] htrans;
  logic            [2:0] hsize;
  logic                  hreadyout, hresp, addr_oe, dq_off, wrap_flag_n;
  logic                  ce_n, ce;
  logic           [17:0] addr_wire, addr_out, count_addr;
  logic           [17:0] e_cnt, e_msk, e_mir;
  logic                  e_flg;
  bac_pkg::bac_port_type port;
  int                    failures = 0;
  int                    comparisons = 0;

  always #5 hclk = ~hclk;

  bac_top bac_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .master_reset_n(master_reset_n),
    .counter_mask_select(port.select), .counter_clear_n(port.clear_n),
    .addr_strobe_n(port.strobe_n), .count_enable_n(port.en_n),
    .chip_en_low_active(ce_n), .chip_en_high_active(ce),
    .addr_in(addr_wire), .addr_out(addr_out), .addr_oe(addr_oe),
    .dq_off(dq_off), .count_addr(count_addr), .wrap_flag_n(wrap_flag_n)
  );

  bac_host bac_host_inst (
    .hclk(hclk), .tie_wrap(tie), .wrap_flag_n(wrap_flag_n),
    .addr_out(addr_out), .addr_oe(addr_oe), .port(port),
    .addr_wire(addr_wire), .ce_n(ce_n), .ce(ce)
  );

  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    failures++;
    end_sim();
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask : ahb

  task automatic model(input bac_pkg::bac_port_type p);
    logic cl;
    cl = tie ? e_flg : p.clear_n;
    if (p.select && !cl)
    begin
      e_cnt = e_cnt & ~e_msk;
      e_mir = e_mir & ~e_msk;
      e_flg = 1'b1;
    end
    else if (p.select && !p.strobe_n && !p.en_n)
    begin
      e_cnt = p.addr;
      e_mir = p.addr;
      e_flg = 1'b1;
    end
    else if (p.select && !p.en_n)
    begin
      if ((e_cnt | ~e_msk) == 18'h3FFFF)
        e_cnt = e_mir;
      else
        e_cnt = (e_cnt & ~e_msk) |
                ((e_cnt + (e_msk[0] ? 18'h00001 : 18'h00002)) & e_msk);
      e_flg = ((e_cnt | ~e_msk) != 18'h3FFFF);
    end
    else if (!p.select && (!cl || (!p.strobe_n && !p.en_n)))
    begin
      e_msk = cl ? p.addr : 18'h3FFFF;
      e_flg = 1'b1;
    end
  endtask : model

  task automatic op(input logic s, input logic cl, input logic st,
                    input logic en, input logic [17:0] a, input int n,
                    input logic ce_on);
    bac_pkg::bac_port_type p;
    p = '{s, cl, st, en, a};
    @(posedge hclk);
    bac_host_inst.apply(p, ce_on);
    for (int i = 0; i < n; i++)
    begin
      @(posedge hclk);
      if (i == n - 1)
        bac_host_inst.apply(bac_pkg::PORT_IDLE, 1'b0);
      #1;
      model(p);
      chk(32'(count_addr), 32'(e_cnt));
      chk({31'h0, wrap_flag_n}, {31'h0, e_flg});
      if (!st && en && cl)
      begin
        chk(32'(addr_out), 32'(s ? e_cnt : e_msk));
        chk({31'h0, addr_oe}, 32'h1);
        chk({31'h0, dq_off}, {31'h0, ce_on});
      end
      else
        chk({31'h0, addr_oe}, 32'h0);
    end
  endtask : op

  initial
  begin
    {hresetn, master_reset_n, hsel, hwrite, tie} = 5'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {e_cnt, e_mir, e_msk, e_flg} = {36'h0, 18'h3FFFF, 1'b1};
    repeat (5) @(posedge hclk);
    hresetn        <= 1'b1;
    master_reset_n <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, 32'(bac_pkg::OFF_MASK), 32'h0, rd);
    chk(rd, 32'h3FFFF);
    chk(32'(count_addr), 32'h0);
    ahb(1'b0, 32'(bac_pkg::OFF_STATUS), 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk({rd[31:1], hresp}, 32'h0);
    $display("test reset done");
    op(1'b0, 1'b1, 1'b0, 1'b0, 18'h0003F, 1, 1'b0);
    op(1'b1, 1'b1, 1'b0, 1'b0, 18'h2A548, 1, 1'b0);
    ahb(1'b0, 32'(bac_pkg::OFF_MIRROR), 32'h0, rd);
    chk(rd, 32'h2A548);
    op(1'b1, 1'b1, 1'b1, 1'b0, 18'h0, 112, 1'b0);
    op(1'b1, 1'b1, 1'b1, 1'b1, 18'h0, 6, 1'b0);
    op(1'b0, 1'b1, 1'b1, 1'b0, 18'h0, 3, 1'b0);
    $display("test mask 3F laps done");
    op(1'b1, 1'b1, 1'b0, 1'b1, 18'h0, 1, 1'b1);
    op(1'b0, 1'b1, 1'b0, 1'b1, 18'h0, 1, 1'b0);
    op(1'b1, 1'b1, 1'b1, 1'b0, 18'h0, 3, 1'b0);
    op(1'b1, 1'b0, 1'b1, 1'b1, 18'h0, 1, 1'b0);
    ahb(1'b0, 32'(bac_pkg::OFF_MIRROR), 32'h0, rd);
    chk(rd, 32'(e_mir));
    $display("test readback and clear done");
    op(1'b0, 1'b1, 1'b0, 1'b0, 18'h003FE, 1, 1'b0);
    op(1'b1, 1'b1, 1'b0, 1'b0, 18'h00102, 1, 1'b0);
    op(1'b1, 1'b1, 1'b1, 1'b0, 18'h0, 400, 1'b0);
    op(1'b0, 1'b0, 1'b1, 1'b1, 18'h0, 1, 1'b0);
    ahb(1'b0, 32'(bac_pkg::OFF_MASK), 32'h0, rd);
    chk(rd, 32'h3FFFF);
    $display("test count by two done");
    op(1'b0, 1'b1, 1'b0, 1'b0, 18'h00003, 1, 1'b0);
    op(1'b1, 1'b1, 1'b0, 1'b0, 18'h00011, 1, 1'b0);
    tie = 1'b1;
    op(1'b1, 1'b1, 1'b1, 1'b0, 18'h0, 12, 1'b0);
    tie = 1'b0;
    $display("test tied flag done");
    ahb(1'b1, 32'(bac_pkg::OFF_CTRL), 32'h1, rd);
    ahb(1'b0, 32'(bac_pkg::OFF_CTRL), 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1'b1, 32'(bac_pkg::OFF_CMD), 32'h0030_0123, rd);
    {e_cnt, e_mir, e_flg} = {18'h00123, 18'h00123, 1'b1};
    ahb(1'b0, 32'(bac_pkg::OFF_COUNT), 32'h0, rd);
    chk(rd, 32'(e_cnt));
    ahb(1'b0, 32'(bac_pkg::OFF_MIRROR), 32'h0, rd);
    chk(rd, 32'(e_mir));
    ahb(1'b1, 32'(bac_pkg::OFF_CTRL), 32'h0, rd);
    op(1'b1, 1'b1, 1'b1, 1'b1, 18'h0, 3, 1'b0);
    $display("test software command done");
    @(posedge hclk);
    master_reset_n <= 1'b0;
    #1;
    chk(32'(count_addr), 32'h0);
    chk({31'h0, wrap_flag_n}, 32'h1);
    repeat (2) @(posedge hclk);
    master_reset_n <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, 32'(bac_pkg::OFF_MASK), 32'h0, rd);
    chk(rd, 32'h3FFFF);
    ahb(1'b0, 32'(bac_pkg::OFF_MIRROR), 32'h0, rd);
    chk(rd, 32'h0);
    $display("test master reset done");
    end_sim();
  end
endmodule : bac_tb_top
